// ==== bench/crcc_raster_cursor_properties.sv ====
`timescale 1ns/100ps
`include "crcc_defs.svh"
module crcc_raster_cursor_properties
  import crcc_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          reset,
  // Host port and timing
  input wire crcc_hostreq_s hostReq,
  input wire logic [7:0]    readData,
  input wire crcc_timing_s  timing,
  // Display outputs
  input wire logic          displayEnableOut,
  input wire logic          cursorVideoOut,
  input wire logic [4:0]    rowLineAddr,
  input wire logic          vsyncOut,
  input wire logic          oddField
);
  logic [4:0] idxReg;
  logic [7:0] skewReg;
  logic [4:0] maxReg;
  logic [2:0] quietCnt;
  logic [3:0] rawHist;
  logic       settled;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Shadow of host writes; quiet time hides pipeline refill after a change
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      idxReg <= 5'h00;
      skewReg <= 8'h00;
      maxReg <= 5'h00;
      quietCnt <= 3'h0;
    end else if (hostReq.chipSel && hostReq.wrStb) begin
      quietCnt <= 3'h0;
      if (!hostReq.dataSel) begin
        idxReg <= hostReq.wrData[4:0];
      end else if (idxReg == `CRCC_IDX_SKEW) begin
        skewReg <= hostReq.wrData;
      end else if (idxReg == `CRCC_IDX_MAXRAS) begin
        maxReg <= hostReq.wrData[4:0];
      end
    end else if (quietCnt != 3'h7) begin
      quietCnt <= quietCnt + 3'h1;
    end
  end

  // History of the unskewed display window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rawHist <= 4'h0;
    end else begin
      rawHist <= {rawHist[2:0], timing.rawDisplay};
    end
  end

  assign settled = quietCnt > 3'h4;

  de_delay_a: assert property (settled && skewReg[7:6] != 2'h3 |-> displayEnableOut == rawHist[skewReg[7:6]])
    else $error("display enable delay wrong");
  de_off_a: assert property (settled && skewReg[7:6] == 2'h3 |-> !displayEnableOut)
    else $error("display enable not suppressed");
  cursor_gate_a: assert property (cursorVideoOut |-> displayEnableOut)
    else $error("cursor outside display enable");
  cursor_off_a: assert property (settled && skewReg[5:4] == 2'h3 |-> !cursorVideoOut)
    else $error("cursor not suppressed");
  ra_bound_a: assert property (settled && !skewReg[0] |-> rowLineAddr <= maxReg)
    else $error("row line address above maximum");
  ra_step_a: assert property (settled && !skewReg[0] && $changed(rowLineAddr) |->
    rowLineAddr == $past(rowLineAddr) + 5'h1 || rowLineAddr == 5'h00)
    else $error("row line address skipped");
  field_none_a: assert property (settled && !skewReg[0] |-> !oddField)
    else $error("odd field in noninterlace");
  field_flip_a: assert property (settled && skewReg[0] && timing.fieldStart |=> oddField != $past(oddField))
    else $error("field parity did not toggle");
  read_zero_a: assert property (hostReq.chipSel && hostReq.rdStb &&
    (!hostReq.dataSel || idxReg < 5'h0E || idxReg > 5'h11) |=> readData == 8'h00)
    else $error("unreadable register gave data");
  read_top_a: assert property (hostReq.chipSel && hostReq.rdStb && hostReq.dataSel &&
    (idxReg == `CRCC_IDX_PENHI || idxReg == `CRCC_IDX_CURHI) |=> readData[7:6] == 2'h0)
    else $error("high register top bits set");
  vsync_follow_a: assert property (!(skewReg[0] && oddField) |=> vsyncOut == $past(timing.vsyncRaw))
    else $error("vertical sync did not follow");
  vsync_half_a: assert property (skewReg[0] && oddField && !timing.halfLine |=> $stable(vsyncOut))
    else $error("odd field sync moved off mid-line");
endmodule

bind crcc_raster_cursor crcc_raster_cursor_properties chk (
  .core_clk(core_clk), .reset(reset), .hostReq(hostReq), .readData(readData), .timing(timing),
  .displayEnableOut(displayEnableOut), .cursorVideoOut(cursorVideoOut), .rowLineAddr(rowLineAddr),
  .vsyncOut(vsyncOut), .oddField(oddField)
);

// ==== bench/crcc_timing_model.sv ====
`timescale 1ns/100ps
module crcc_timing_model
  import crcc_pkg::*;
#(
  parameter int HT = 8,
  parameter int HD = 4,
  parameter int VT = 8,
  parameter int VD = 6
) (
  // Clock, reset and run control
  input  wire logic    core_clk,
  input  wire logic    reset,
  input  wire logic    run,
  // Strobes into the block
  output crcc_timing_s timing
);
  int hPos;
  int vPos;

  // Counters hold while stopped so a frame resumes where it left off
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hPos <= 0;
      vPos <= 0;
    end else if (run) begin
      hPos <= (hPos == HT - 1) ? 0 : hPos + 1;
      if (hPos == HT - 1) begin
        vPos <= (vPos == VT - 1) ? 0 : vPos + 1;
      end
    end
  end

  // Strobes drop to zero when stopped, never a stale edge
  always_comb begin
    timing.rawDisplay = run && hPos < HD && vPos < VD;
    timing.lineEnd    = run && hPos == HT - 1;
    timing.halfLine   = run && hPos == HT / 2;
    timing.fieldStart = run && hPos == HT - 1 && vPos == VT - 1;
    timing.vsyncRaw   = run && vPos == VT - 1;
  end
endmodule

// ==== bench/tb_crt_raster_cursor_control.sv ====
`timescale 1ns/100ps
`include "crcc_defs.svh"
module tb_crt_raster_cursor_control
  import crcc_pkg::*;
;
  logic          core_clk = 1'b0;
  logic          reset = 1'b1;
  crcc_hostreq_s hostReq = '0;
  crcc_timing_s  timing;
  logic          penStrobeIn = 1'b0;
  logic          run = 1'b0;
  logic [7:0]    readData;
  logic          displayEnableOut;
  logic          cursorVideoOut;
  logic [4:0]    rowLineAddr;
  logic [13:0]   refreshAddr;
  logic          vsyncOut;
  logic          oddField;
  logic          oddSeen;
  int            err_total = 0;
  int            num_checks = 0;
  int            deCnt;
  int            cuCnt;

  // Character clock
  always #4 core_clk = ~core_clk;

  crcc_timing_model model (.core_clk(core_clk), .reset(reset), .run(run), .timing(timing));

  crcc_raster_cursor dut (
    .core_clk(core_clk), .reset(reset), .hostReq(hostReq), .readData(readData), .timing(timing),
    .penStrobeIn(penStrobeIn), .displayEnableOut(displayEnableOut), .cursorVideoOut(cursorVideoOut),
    .rowLineAddr(rowLineAddr), .refreshAddr(refreshAddr), .vsyncOut(vsyncOut), .oddField(oddField)
  );

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One host cycle, launched just after an edge
  task automatic hostCyc(input logic ds, input logic rd, input logic [7:0] d);
    @(posedge core_clk);
    hostReq <= '{1'b1, ds, !rd, rd, d};
  endtask

  task automatic wrReg(input logic [4:0] idx, input logic [7:0] d);
    hostCyc(1'b0, 1'b0, {3'h0, idx});
    hostCyc(1'b1, 1'b0, d);
    @(posedge core_clk);
    hostReq <= '0;
  endtask

  task automatic rdChk(input logic [4:0] idx, input logic [7:0] exp);
    hostCyc(1'b0, 1'b0, {3'h0, idx});
    hostCyc(1'b1, 1'b1, 8'h00);
    @(posedge core_clk);
    hostReq <= '0;
    @(posedge core_clk);
    chk({8'h00, readData}, {8'h00, exp});
  endtask

  // Count enable and cursor characters over whole fields
  task automatic runFields(input int n);
    int f;
    f = 0;
    deCnt = 0;
    cuCnt = 0;
    @(posedge core_clk iff timing.fieldStart);
    while (f < n) begin
      @(posedge core_clk);
      if (timing.fieldStart) f++;
      deCnt += displayEnableOut;
      cuCnt += cursorVideoOut;
    end
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 14; i < 18; i++) rdChk(5'(i), 8'h00);
    wrReg(`CRCC_IDX_CURHI, 8'h2A);
    wrReg(`CRCC_IDX_CURLO, 8'h5C);
    wrReg(`CRCC_IDX_PENHI, 8'hFF);
    wrReg(5'h14, 8'hFF);
    rdChk(`CRCC_IDX_CURHI, 8'h2A);
    rdChk(`CRCC_IDX_CURLO, 8'h5C);
    rdChk(`CRCC_IDX_PENHI, 8'h00);
    rdChk(5'h14, 8'h00);
    $display("Test registers finished");
    wrReg(`CRCC_IDX_MAXRAS, 8'h02);
    wrReg(`CRCC_IDX_CUREND, 8'h02);
    wrReg(`CRCC_IDX_CURHI, 8'h00);
    wrReg(`CRCC_IDX_CURLO, 8'h05);
    wrReg(`CRCC_IDX_CURSTART, 8'h01);
    // Cursor skew runs opposite to enable skew to show they are separate
    for (int c = 0; c < 4; c++) begin
      run <= 1'b0;
      wrReg(`CRCC_IDX_SKEW, {2'(c), 2'(3 - c), 4'h0});
      run <= 1'b1;
      runFields(2);
      chk(16'(deCnt), c == 3 ? 16'h0000 : 16'h0030);
      chk(16'(cuCnt), (c == 0 || c == 3) ? 16'h0000 : 16'h0004);
    end
    $display("Test skew finished");
    for (int m = 0; m < 4; m++) begin
      run <= 1'b0;
      wrReg(`CRCC_IDX_SKEW, 8'h00);
      wrReg(`CRCC_IDX_CURSTART, {1'b0, 2'(m), 5'h01});
      run <= 1'b1;
      runFields(32);
      chk(16'(cuCnt), m == 1 ? 16'h0000 : (m == 0 ? 16'h0040 : 16'h0020));
    end
    $display("Test cursor modes finished");
    for (int k = 1; k < 4; k += 2) begin
      run <= 1'b0;
      wrReg(`CRCC_IDX_SKEW, 8'(k));
      run <= 1'b1;
      runFields(1);
      oddSeen = oddField;
      // One edge past the field start, so that exactly one toggle is seen
      @(posedge core_clk);
      chk({15'h0000, oddField}, {15'h0000, !oddSeen});
    end
    run <= 1'b0;
    wrReg(`CRCC_IDX_SKEW, 8'h00);
    run <= 1'b1;
    runFields(1);
    chk({15'h0000, oddField}, 16'h0000);
    $display("Test interlace finished");
    run <= 1'b0;
    wrReg(`CRCC_IDX_STARTHI, 8'h35);
    wrReg(`CRCC_IDX_STARTLO, 8'h67);
    run <= 1'b1;
    @(posedge core_clk iff timing.fieldStart);
    penStrobeIn <= 1'b1;
    @(posedge core_clk);
    penStrobeIn <= 1'b0;
    run <= 1'b0;
    rdChk(`CRCC_IDX_PENHI, 8'h35);
    rdChk(`CRCC_IDX_PENLO, 8'h67);
    $display("Test light pen finished");
    report_and_stop;
  end

  // Watchdog well beyond the expected ten thousand cycles
  initial begin
    #320000;
    err_total++;
    report_and_stop;
  end
endmodule

// ==== include/crcc_defs.svh ====
`ifndef CRCC_DEFS_SVH
`define CRCC_DEFS_SVH

// Control register indices reached through the index register
`define CRCC_IDX_SKEW        5'h08
`define CRCC_IDX_MAXRAS      5'h09
`define CRCC_IDX_CURSTART    5'h0A
`define CRCC_IDX_CUREND      5'h0B
`define CRCC_IDX_STARTHI     5'h0C
`define CRCC_IDX_STARTLO     5'h0D
`define CRCC_IDX_CURHI       5'h0E
`define CRCC_IDX_CURLO       5'h0F
`define CRCC_IDX_PENHI       5'h10
`define CRCC_IDX_PENLO       5'h11

// Field positions in the interlace and skew register
`define CRCC_SYNC_BIT        0
`define CRCC_VIDEO_BIT       1
`define CRCC_CUSKEW_LSB      4
`define CRCC_DESKEW_LSB      6

// Field positions in the cursor start register
`define CRCC_CMODE_LSB       5

// Skew codes
`define CRCC_SKEW_ZERO       2'h0
`define CRCC_SKEW_ONE        2'h1
`define CRCC_SKEW_TWO        2'h2
`define CRCC_SKEW_OFF        2'h3

// Cursor display modes
`define CRCC_CMODE_STEADY    2'h0
`define CRCC_CMODE_OFF       2'h1
`define CRCC_CMODE_BLINK16   2'h2
`define CRCC_CMODE_BLINK32   2'h3

// Blink counter bits giving 16 and 32 field periods
`define CRCC_BLINK16_BIT     3
`define CRCC_BLINK32_BIT     4

// Reset values
`define CRCC_RESET_BYTE      8'h00
`define CRCC_RESET_INDEX     5'h00

`endif

// ==== include/crcc_pkg.sv ====
package crcc_pkg;

  // Raster scan modes
  typedef enum logic [1:0] {
    SCAN_NONINTERLACE,
    SCAN_INTERLACE_SYNC,
    SCAN_SYNC_VIDEO
  } crcc_scan_e;

  // Host register port request
  typedef struct packed {
    logic       chipSel;
    logic       dataSel;
    logic       wrStb;
    logic       rdStb;
    logic [7:0] wrData;
  } crcc_hostreq_s;

  // Timing strobes from the horizontal and vertical counters
  typedef struct packed {
    logic rawDisplay;
    logic lineEnd;
    logic halfLine;
    logic fieldStart;
    logic vsyncRaw;
  } crcc_timing_s;

endpackage

// ==== verilog/crcc_raster_cursor.sv ====
`timescale 1ns/100ps
`include "crcc_defs.svh"
// Function
// - Sync and video bits select scan mode
// - Display-enable skew: zero, one, two, none
// - Cursor skew field set independently, 00 zero
// - Noninterlace row spans max raster plus one
// - Interlace sync row spans that same count
// - Sync-video row spans plus one, fields split
// - Cursor start raster plus four display modes
// - Cursor end sets last cursor raster
// - Start address gives first fetched word
// - Cursor position readable; high bits read zero
// - Pen registers latch address; high bits zero
// - Interlace vertical sync width shifts half raster
// - Noninterlace fields identical, addresses count up
// - Interlace sync odd field half raster lower
// - Sync-video even and odd rasters differ
// - Cursor forced low while display enable low
// - Pen strobe captures address, mode, bank
// - Five-bit index selects register; 18+ ignored
module crcc_raster_cursor
  import crcc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset,
  // Host register port
  input  wire crcc_hostreq_s hostReq,
  output logic [7:0]         readData,
  // Timing from the rest of the controller
  input  wire crcc_timing_s  timing,
  input  wire logic          penStrobeIn,
  // Display circuit outputs
  output logic               displayEnableOut,
  output logic               cursorVideoOut,
  output logic [4:0]         rowLineAddr,
  output logic [13:0]        refreshAddr,
  output logic               vsyncOut,
  output logic               oddField
);

  logic [4:0]        index_reg;
  logic [7:0]        skewCtl_reg;
  logic [4:0]        maxRaster_reg;
  logic [6:0]        curStart_reg;
  logic [7:0]        curEnd_reg;
  logic [7:0]        startHi_reg;
  logic [7:0]        startLo_reg;
  logic [5:0]        curHi_reg;
  logic [7:0]        curLo_reg;
  logic [13:0]       penLatch_reg;
  logic [7:0]        readData_reg;
  logic [4:0]        ra_reg;
  logic              odd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] rowBase_reg;
  logic [4:0]        blink_reg;
  logic [1:0]        deDly_reg;
  logic [1:0]        cuDly_reg;
  logic              deOut_reg;
  logic              cuOut_reg;
  logic              vsync_reg;
  logic              penPrev_reg;
  crcc_scan_e        scanMode;
  logic              rowLast;
  logic              interlaced;
  logic              cursorRaw;
  logic              blinkOn;
  logic [13:0]       cursorPos;
  logic [ADDR_W-1:0] startAddr;
  logic              hostWr;
  logic              hostRd;

  // Scan mode from the sync and video bits; sync clear wins
  function automatic crcc_scan_e decodeScan(input logic [7:0] ctl);
    if (!ctl[`CRCC_SYNC_BIT]) begin
      return SCAN_NONINTERLACE;
    end
    return ctl[`CRCC_VIDEO_BIT] ? SCAN_SYNC_VIDEO : SCAN_INTERLACE_SYNC;
  endfunction

  // Pick a delayed copy; code 11 gives no output at all
  function automatic logic skewSelect(input logic [1:0] code, input logic now, input logic [1:0] dly);
    case (code)
      `CRCC_SKEW_ZERO: return now;
      `CRCC_SKEW_ONE:  return dly[0];
      `CRCC_SKEW_TWO:  return dly[1];
      default:         return 1'b0;
    endcase
  endfunction

  assign scanMode   = decodeScan(skewCtl_reg);
  assign interlaced = scanMode != SCAN_NONINTERLACE;
  assign hostWr     = hostReq.chipSel & hostReq.wrStb;
  assign hostRd     = hostReq.chipSel & hostReq.rdStb;
  assign cursorPos  = {curHi_reg, curLo_reg};
  assign startAddr  = ADDR_W'({startHi_reg, startLo_reg});

  // Last raster of a character row in this field
  always_comb begin
    if (scanMode == SCAN_SYNC_VIDEO) begin
      rowLast = ({1'b0, ra_reg} + 6'h01) >= {1'b0, maxRaster_reg};
    end else begin
      rowLast = ra_reg >= maxRaster_reg;
    end
  end

  // Index register; values 18..31 select nothing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      index_reg <= `CRCC_RESET_INDEX;
    end else if (hostWr && !hostReq.dataSel) begin
      index_reg <= hostReq.wrData[4:0];
    end
  end

  // Writable control registers; indices below 8 live elsewhere
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      skewCtl_reg   <= `CRCC_RESET_BYTE;
      maxRaster_reg <= 5'h00;
      curStart_reg  <= 7'h00;
      curEnd_reg    <= `CRCC_RESET_BYTE;
      startHi_reg   <= `CRCC_RESET_BYTE;
      startLo_reg   <= `CRCC_RESET_BYTE;
      curHi_reg     <= 6'h00;
      curLo_reg     <= `CRCC_RESET_BYTE;
    end else if (hostWr && hostReq.dataSel) begin
      case (index_reg)
        `CRCC_IDX_SKEW:     skewCtl_reg   <= hostReq.wrData;
        `CRCC_IDX_MAXRAS:   maxRaster_reg <= hostReq.wrData[4:0];
        `CRCC_IDX_CURSTART: curStart_reg  <= hostReq.wrData[6:0];
        `CRCC_IDX_CUREND:   curEnd_reg    <= hostReq.wrData;
        `CRCC_IDX_STARTHI:  startHi_reg   <= hostReq.wrData;
        `CRCC_IDX_STARTLO:  startLo_reg   <= hostReq.wrData;
        `CRCC_IDX_CURHI:    curHi_reg     <= hostReq.wrData[5:0];
        `CRCC_IDX_CURLO:    curLo_reg     <= hostReq.wrData;
        default: ;
      endcase
    end
  end

  // Read port: cursor and pen registers only, all else reads zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readData_reg <= `CRCC_RESET_BYTE;
    end else if (hostRd) begin
      if (!hostReq.dataSel) begin
        readData_reg <= `CRCC_RESET_BYTE;
      end else begin
        case (index_reg)
          `CRCC_IDX_CURHI: readData_reg <= {2'h0, curHi_reg};
          `CRCC_IDX_CURLO: readData_reg <= curLo_reg;
          `CRCC_IDX_PENHI: readData_reg <= {2'h0, penLatch_reg[13:8]};
          `CRCC_IDX_PENLO: readData_reg <= penLatch_reg[7:0];
          default:         readData_reg <= `CRCC_RESET_BYTE;
        endcase
      end
    end
  end

  // Field parity; only interlaced modes alternate
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      odd_reg   <= 1'b0;
      blink_reg <= 5'h00;
    end else if (timing.fieldStart) begin
      odd_reg   <= interlaced ? ~odd_reg : 1'b0;
      blink_reg <= blink_reg + 5'h01;
    end
  end

  // Raster address; sync-video steps by two from the field parity
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ra_reg <= 5'h00;
    end else if (timing.fieldStart) begin
      ra_reg <= (scanMode == SCAN_SYNC_VIDEO) ? {4'h0, ~odd_reg} : 5'h00;
    end else if (timing.lineEnd) begin
      if (rowLast) begin
        ra_reg <= (scanMode == SCAN_SYNC_VIDEO) ? {4'h0, odd_reg} : 5'h00;
      end else begin
        ra_reg <= ra_reg + ((scanMode == SCAN_SYNC_VIDEO) ? 5'h02 : 5'h01);
      end
    end
  end

  // Refresh address: each raster of a row re-reads the row from its base
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addr_reg    <= '0;
      rowBase_reg <= '0;
    end else if (timing.fieldStart) begin
      addr_reg    <= startAddr;
      rowBase_reg <= startAddr;
    end else if (timing.lineEnd) begin
      if (rowLast) begin
        rowBase_reg <= addr_reg;
      end else begin
        addr_reg <= rowBase_reg;
      end
    end else if (timing.rawDisplay) begin
      addr_reg <= addr_reg + ADDR_W'(1);
    end
  end

  // Blink gating and raw cursor at the current character
  always_comb begin
    case (curStart_reg[`CRCC_CMODE_LSB +: 2])
      `CRCC_CMODE_STEADY:  blinkOn = 1'b1;
      `CRCC_CMODE_OFF:     blinkOn = 1'b0;
      `CRCC_CMODE_BLINK16: blinkOn = blink_reg[`CRCC_BLINK16_BIT];
      default:             blinkOn = blink_reg[`CRCC_BLINK32_BIT];
    endcase
  end
  assign cursorRaw = timing.rawDisplay && blinkOn && (refreshAddr == cursorPos)
                     && (ra_reg >= curStart_reg[4:0]) && ({3'h0, ra_reg} <= curEnd_reg);

  // Skew delay lines, one character per stage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      deDly_reg <= 2'h0;
      cuDly_reg <= 2'h0;
    end else begin
      deDly_reg <= {deDly_reg[0], timing.rawDisplay};
      cuDly_reg <= {cuDly_reg[0], cursorRaw};
    end
  end

  // Skewed outputs; cursor is masked by the skewed display enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      deOut_reg <= 1'b0;
      cuOut_reg <= 1'b0;
    end else begin
      deOut_reg <= skewSelect(skewCtl_reg[`CRCC_DESKEW_LSB +: 2], timing.rawDisplay, deDly_reg);
      cuOut_reg <= skewSelect(skewCtl_reg[`CRCC_CUSKEW_LSB +: 2], cursorRaw, cuDly_reg)
                   & skewSelect(skewCtl_reg[`CRCC_DESKEW_LSB +: 2], timing.rawDisplay, deDly_reg);
    end
  end

  // Vertical sync: in the odd interlaced field edges move to mid-line
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vsync_reg <= 1'b0;
    end else if (!(interlaced && odd_reg) || timing.halfLine) begin
      vsync_reg <= timing.vsyncRaw;
    end
  end

  // Light pen capture on the strobe's rising edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      penPrev_reg  <= 1'b0;
      penLatch_reg <= 14'h0000;
    end else begin
      penPrev_reg <= penStrobeIn;
      if (penStrobeIn && !penPrev_reg) begin
        penLatch_reg <= refreshAddr;
      end
    end
  end

  // Upper refresh bits carry the hires and font bank settings
  assign refreshAddr      = {startHi_reg[5:4], 12'(addr_reg)};
  assign rowLineAddr      = ra_reg;
  assign oddField         = odd_reg;
  assign vsyncOut         = vsync_reg;
  assign displayEnableOut = deOut_reg;
  assign cursorVideoOut   = cuOut_reg;
  assign readData         = readData_reg;

endmodule
